// ==== ptbi_pkg.sv ====
// package: register map, field layout and divider ratios of the timebase
package ptbi_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [3:0] PTBI_OFS_CTRL = 4'h0; // timebase_control
  localparam logic [3:0] PTBI_OFS_CFG  = 4'h4; // timebase_config

  // ---------------------------------------------------------------
  // timebase_control field positions, plus the one timebase_config bit
  // ---------------------------------------------------------------
  localparam int PTBI_POS_PEND = 7; // tick_pending_flag, read only
  localparam int PTBI_POS_RATE = 4; // tick_rate_select, bits 6:4
  localparam int PTBI_POS_ACK  = 3; // tick_acknowledge, write only
  localparam int PTBI_POS_IE   = 2; // tick_irq_enable
  localparam int PTBI_POS_ON   = 1; // tick_counter_on
  localparam int PTBI_POS_OSC  = 0; // osc_run_in_stop in timebase_config

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] PTBI_RST_RATE = 3'h0;
  localparam logic       PTBI_RST_IE   = 1'b0;
  localparam logic       PTBI_RST_ON   = 1'b0;
  localparam logic       PTBI_RST_OSC  = 1'b0;

  // ---------------------------------------------------------------
  // divider ratio for each rate code, in crystal cycles
  // ---------------------------------------------------------------
  localparam int PTBI_DIV_0 = 32768;
  localparam int PTBI_DIV_1 = 8192;
  localparam int PTBI_DIV_2 = 2048;
  localparam int PTBI_DIV_3 = 128;
  localparam int PTBI_DIV_4 = 64;
  localparam int PTBI_DIV_5 = 32;
  localparam int PTBI_DIV_6 = 16;
  localparam int PTBI_DIV_7 = 8;
  localparam int PTBI_STAGES = 15; // divider chain length

  // software-visible control state
  typedef struct packed {
    logic [2:0] rate;   // tick_rate_select
    logic       irq_en; // tick_irq_enable
    logic       on;     // tick_counter_on
    logic       osc;    // osc_run_in_stop
  } ptbi_ctrl_t;

  // bus answer state
  typedef enum logic [0:0] {
    PTBI_IDLE = 1'b0,
    PTBI_ANS  = 1'b1
  } ptbi_bus_t;

endpackage : ptbi_pkg

// ==== ptbi_top.sv ====
// periodic timebase interrupt generator with Avalon-MM control register
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
// Function
// - set pending flag on selected tap rollover
// - pending flag read only, reads current state
// - codes 0..2 divide 32768, 8192, 2048
// - codes 3..7 divide 128 down to 8
// - acknowledge bit always reads zero
// - writing one to acknowledge clears flag
// - request only when flag and enable set
// - reset clears irq enable and counter on
// - counter held at zero while off
// - counts in wait, registers blocked
// - in stop runs only with oscillator allowed
// - event during stop wakes the processor when irq enable is set
// - fifteen stages clocked by crystal clock
// - first event at half, then full period
module ptbi_top
  import ptbi_pkg::*;
#(
  parameter int STAGES = PTBI_STAGES // divider chain length
) (
  input  wire logic        ref_clk,          // system clock, 125 MHz
  input  wire logic        nrst,             // sync reset, active low
  input  wire logic [3:0]  avs_address,      // byte address
  input  wire logic        avs_read,         // read request
  input  wire logic        avs_write,        // write request
  input  wire logic [31:0] avs_writedata,    // write data
  input  wire logic [3:0]  avs_byteenable,   // byte lanes
  output logic      [31:0] avs_readdata,     // read data
  output logic             avs_waitrequest,  // stall, active high
  input  wire logic        crystal_clock,    // crystal, sampled
  input  wire logic        wait_mode,        // processor in wait
  input  wire logic        stop_mode,        // processor in stop
  output logic             tick_irq,         // interrupt request
  output logic             tick_wakeup,      // wakeup from stop
  output logic             tick_pending_flag // pending, for status
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (STAGES != PTBI_STAGES) begin : g_bad_stages
    $error("ptbi_top: divider chain must have fifteen stages");
  end

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // tap bit whose rising edge marks one event; bit k rises every
  // 2^(k+1) crystal cycles, so divide-by-N uses bit log2(N)-1
  function automatic logic [3:0] tap_of(input logic [2:0] rate);
    logic [3:0] t;
    t = 4'h0;
    case (rate)
      3'h0:    t = 4'(($clog2(PTBI_DIV_0)) - 1);
      3'h1:    t = 4'(($clog2(PTBI_DIV_1)) - 1);
      3'h2:    t = 4'(($clog2(PTBI_DIV_2)) - 1);
      3'h3:    t = 4'(($clog2(PTBI_DIV_3)) - 1);
      3'h4:    t = 4'(($clog2(PTBI_DIV_4)) - 1);
      3'h5:    t = 4'(($clog2(PTBI_DIV_5)) - 1);
      3'h6:    t = 4'(($clog2(PTBI_DIV_6)) - 1);
      3'h7:    t = 4'(($clog2(PTBI_DIV_7)) - 1);
      default: t = 4'h0;
    endcase
    return t;
  endfunction : tap_of

  // register address match on the word, ignoring the lane bits
  function automatic logic hit(input logic [3:0] a,
                               input logic [3:0] ofs);
    return a[3:2] == ofs[3:2];
  endfunction : hit

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ptbi_ctrl_t         ctrl_r;
  ptbi_bus_t          bus_r;
  logic [STAGES-1:0]  div_r;
  logic               xtal_r;
  logic               tap_r;
  logic               pend_r;
  logic               irq_r;
  logic               wake_r;
  logic [31:0]        rdata_r;

  logic               lowpwr;
  logic               run;
  logic               xtal_rise;
  logic               tap_now;
  logic               tick;
  logic               req;
  logic               commit_wr;
  logic               ack_wr;
  logic [31:0]        rd_val;

  // ---------------------------------------------------------------
  // bus slave: one wait cycle, then the answer
  // ---------------------------------------------------------------
  // while sleeping the processor cannot reach the register, so a
  // stray access completes normally but reads zero and writes nothing
  assign lowpwr = wait_mode | stop_mode;
  assign req    = avs_read | avs_write;
  assign commit_wr = (bus_r == PTBI_ANS) & avs_write & ~lowpwr;
  assign ack_wr = commit_wr & hit(avs_address, PTBI_OFS_CTRL) &
                  avs_byteenable[0] & avs_writedata[PTBI_POS_ACK];

  // answer sequencer
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bus_r <= PTBI_IDLE;
    end else begin
      case (bus_r)
        PTBI_IDLE: if (req) bus_r <= PTBI_ANS;
        PTBI_ANS:  bus_r <= PTBI_IDLE;
        default:   bus_r <= PTBI_IDLE;
      endcase
    end
  end

  // waitrequest high except in the answer cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((bus_r == PTBI_IDLE) && req);
    end
  end

  // read mux; acknowledge bit is never returned
  always_comb begin
    rd_val = 32'h0000_0000;
    if (!lowpwr) begin
      if (hit(avs_address, PTBI_OFS_CTRL)) begin
        rd_val[PTBI_POS_PEND] = pend_r;
        rd_val[PTBI_POS_RATE +: 3] = ctrl_r.rate;
        rd_val[PTBI_POS_ACK] = 1'b0;
        rd_val[PTBI_POS_IE] = ctrl_r.irq_en;
        rd_val[PTBI_POS_ON] = ctrl_r.on;
      end else if (hit(avs_address, PTBI_OFS_CFG)) begin
        rd_val[PTBI_POS_OSC] = ctrl_r.osc;
      end
    end
  end

  // read data captured in the wait cycle, stable at the answer edge
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_r <= 32'h0000_0000;
    end else if ((bus_r == PTBI_IDLE) && avs_read) begin
      rdata_r <= rd_val;
    end
  end
  assign avs_readdata = rdata_r;

  // control register writes; the pending bit has no write path
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_r.rate   <= PTBI_RST_RATE;
      ctrl_r.irq_en <= PTBI_RST_IE;
      ctrl_r.on     <= PTBI_RST_ON;
      ctrl_r.osc    <= PTBI_RST_OSC;
    end else if (commit_wr && avs_byteenable[0]) begin
      if (hit(avs_address, PTBI_OFS_CTRL)) begin
        // rate changes while on are legal here but may skip a tick
        ctrl_r.rate   <= avs_writedata[PTBI_POS_RATE +: 3];
        ctrl_r.irq_en <= avs_writedata[PTBI_POS_IE];
        ctrl_r.on     <= avs_writedata[PTBI_POS_ON];
      end else if (hit(avs_address, PTBI_OFS_CFG)) begin
        ctrl_r.osc <= avs_writedata[PTBI_POS_OSC];
      end
    end
  end

  // ---------------------------------------------------------------
  // divider chain
  // ---------------------------------------------------------------
  // stop with the oscillator halted freezes the chain in place
  assign run = ctrl_r.on & ~(stop_mode & ~ctrl_r.osc);

  // crystal edge detect; the input is already synchronous
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      xtal_r <= 1'b0;
    end else begin
      xtal_r <= crystal_clock;
    end
  end
  assign xtal_rise = crystal_clock & ~xtal_r;

  // count crystal edges; clear while off
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      div_r <= '0;
    end else if (!ctrl_r.on) begin
      div_r <= '0;
    end else if (run && xtal_rise) begin
      div_r <= div_r + 1'b1;
    end
  end

  // rising edge of the tap: first after N/2, then every N
  assign tap_now = div_r[tap_of(ctrl_r.rate)];
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tap_r <= 1'b0;
    end else begin
      tap_r <= tap_now;
    end
  end
  assign tick = tap_now & ~tap_r & ctrl_r.on;

  // ---------------------------------------------------------------
  // pending flag, request and wakeup
  // ---------------------------------------------------------------
  // a tick in the same cycle as an acknowledge wins the flag
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pend_r <= 1'b0;
    end else if (tick) begin
      pend_r <= 1'b1;
    end else if (ack_wr) begin
      pend_r <= 1'b0;
    end
  end
  assign tick_pending_flag = pend_r;

  // level request while flag and enable both hold
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= pend_r & ctrl_r.irq_en;
    end
  end
  assign tick_irq = irq_r;

  // wakeup from stop on a pending event with irq enable set
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= stop_mode & pend_r & ctrl_r.irq_en;
    end
  end
  assign tick_wakeup = wake_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_tick_sets_flag: assert property (
    tick |=> pend_r) else $error("tick did not set pending flag");

  a_no_sw_set: assert property (
    !pend_r && !tick |=> !pend_r)
    else $error("pending flag rose without a tick");

  // an increment lifts the tap only when every lower bit is zero
  a_tap_rate: assert property (
    tick |-> div_r[tap_of(ctrl_r.rate)] &&
             ((div_r << (STAGES - tap_of(ctrl_r.rate))) == '0))
    else $error("tick not on the selected tap edge");

  a_ack_reads_zero: assert property (
    (bus_r == PTBI_ANS) && avs_read |-> !avs_readdata[PTBI_POS_ACK])
    else $error("acknowledge bit read as one");

  a_ack_clears: assert property (
    ack_wr && !tick |=> !pend_r)
    else $error("acknowledge did not clear flag");

  a_irq_level: assert property (
    ##1 tick_irq == $past(pend_r && ctrl_r.irq_en))
    else $error("request does not follow flag and enable");

  a_irq_holds: assert property (
    tick_irq && pend_r && ctrl_r.irq_en |=> tick_irq)
    else $error("request dropped while flag and enable set");

  a_off_zero: assert property (
    !ctrl_r.on |=> div_r == '0)
    else $error("divider not zero while off");

  a_stop_hold: assert property (
    stop_mode && !ctrl_r.osc && ctrl_r.on |=> $stable(div_r))
    else $error("divider moved in stop without oscillator");

  a_sleep_no_write: assert property (
    (bus_r == PTBI_ANS) && avs_write && lowpwr |=> $stable(ctrl_r))
    else $error("register written during low power");

  a_wake_cause: assert property (
    stop_mode && pend_r && ctrl_r.irq_en ##1 stop_mode |-> tick_wakeup)
    else $error("no wakeup on pending event in stop");

  a_answer_time: assert property (
    (bus_r == PTBI_IDLE) && req |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not in one wait cycle");

  // the chain moves by exactly one on each crystal edge while running
  a_div_step: assert property (
    run && xtal_rise |=> div_r == $past(div_r) + 1'b1)
    else $error("divider did not advance on crystal edge");

  a_div_idle: assert property (
    ctrl_r.on && !xtal_rise |=> $stable(div_r))
    else $error("divider moved without a crystal edge");

  a_start_zero: assert property (
    $rose(ctrl_r.on) |-> div_r == '0)
    else $error("counting did not start from zero");

  a_irq_off: assert property (
    !ctrl_r.irq_en |=> !tick_irq)
    else $error("request raised with enable clear");

  a_wake_off: assert property (
    !stop_mode |=> !tick_wakeup)
    else $error("wakeup raised outside stop");

  // reset is checked while it is applied, so the default disable is off
  a_reset_clear: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    !nrst |=> !ctrl_r.irq_en && !ctrl_r.on)
    else $error("reset did not clear the enables");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  c_tick_seen:   cover property (tick);
  c_slow_rate:   cover property (tick && ctrl_r.rate == 3'h0);
  c_ack_tick:    cover property (tick && ack_wr);
  c_irq_raised:  cover property (!tick_irq ##1 tick_irq);
  c_stop_wakeup: cover property (stop_mode && tick_wakeup);

endmodule : ptbi_top

// ==== ptbi_tb.sv ====
// self-checking testbench for the periodic timebase interrupt block
`timescale 1ns/10ps
module testbench;
  import ptbi_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        crystal_clock = 1'b0;
  logic        wait_mode = 1'b0;
  logic        stop_mode = 1'b0;
  logic        tick_irq;
  logic        tick_wakeup;
  logic        tick_pending_flag;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic [31:0] rd;
  int          dv [8] = '{PTBI_DIV_0, PTBI_DIV_1, PTBI_DIV_2, PTBI_DIV_3,
                          PTBI_DIV_4, PTBI_DIV_5, PTBI_DIV_6, PTBI_DIV_7};

  ptbi_top ptbi_top_i (
    .ref_clk           (ref_clk),
    .nrst              (nrst),
    .avs_address       (avs_address),
    .avs_read          (avs_read),
    .avs_write         (avs_write),
    .avs_writedata     (avs_writedata),
    .avs_byteenable    (avs_byteenable),
    .avs_readdata      (avs_readdata),
    .avs_waitrequest   (avs_waitrequest),
    .crystal_clock     (crystal_clock),
    .wait_mode         (wait_mode),
    .stop_mode         (stop_mode),
    .tick_irq          (tick_irq),
    .tick_wakeup       (tick_wakeup),
    .tick_pending_flag (tick_pending_flag)
  );

  // 8 ns clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // hang guard: longest run is the slow rate codes, about 45k cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one Avalon access; an edge passes first so strobes never clash
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge ref_clk);
      n = n + 1;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    chk("bus answer", 32'(n), 32'h2);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  // n crystal rising edges, then time for the flag and request to land
  task automatic xtal(input int n);
    repeat (n) begin
      @(posedge ref_clk) crystal_clock <= 1'b1;
      @(posedge ref_clk) crystal_clock <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
  endtask : xtal

  // off with acknowledge, then on: counter restarts from zero
  task automatic start(input logic [2:0] c, input logic ie);
    bus(1'b1, PTBI_OFS_CTRL, {1'b0, c, 1'b1, 3'h0}, rd);
    bus(1'b1, PTBI_OFS_CTRL, {1'b0, c, 1'b0, ie, 2'b10}, rd);
  endtask : start

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    bus(1'b0, PTBI_OFS_CTRL, 8'h0, rd);
    chk("ctrl reset", rd, 32'h0);
    bus(1'b0, PTBI_OFS_CFG, 8'h0, rd);
    chk("cfg reset", rd, 32'h0);
    bus(1'b1, 4'h8, 8'hFF, rd);
    bus(1'b0, 4'h8, 8'h0, rd);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, PTBI_OFS_CTRL, 8'h80, rd);
    bus(1'b0, PTBI_OFS_CTRL, 8'h0, rd);
    chk("pend write", rd, 32'h0);
  endtask : t_reset

  // every rate code: half period first; full period after for codes 3..7 only
  task automatic t_rates();
    for (int c = 0; c < 8; c++) begin
      start(c[2:0], 1'b1);
      xtal(dv[c] / 2 - 1);
      chk("pend early", tick_pending_flag, 1'b0);
      xtal(1);
      chk("pend half", tick_pending_flag, 1'b1);
      chk("irq", tick_irq, 1'b1);
      bus(1'b0, PTBI_OFS_CTRL, 8'h0, rd);
      chk("ctrl read", rd, {24'h0, 1'b1, c[2:0], 4'h6});
      if (c >= 3) begin
        bus(1'b1, PTBI_OFS_CTRL, {1'b0, c[2:0], 4'hE}, rd);
        repeat (2) @(posedge ref_clk);
        chk("ack", tick_pending_flag, 1'b0);
        chk("irq low", tick_irq, 1'b0);
        xtal(dv[c] - 1);
        chk("pend full-1", tick_pending_flag, 1'b0);
        xtal(1);
        chk("pend full", tick_pending_flag, 1'b1);
      end
    end
  endtask : t_rates

  task automatic t_ack_mask();
    bus(1'b1, PTBI_OFS_CTRL, 8'h72, rd);
    repeat (2) @(posedge ref_clk);
    chk("ack zero", tick_pending_flag, 1'b1);
    chk("irq masked", tick_irq, 1'b0);
    start(3'h7, 1'b1);
    xtal(3);
    start(3'h7, 1'b1);
    xtal(3);
    chk("restart", tick_pending_flag, 1'b0);
    xtal(1);
    chk("restart ev", tick_pending_flag, 1'b1);
  endtask : t_ack_mask

  task automatic t_low_power();
    start(3'h7, 1'b1);
    wait_mode <= 1'b1;
    bus(1'b1, PTBI_OFS_CTRL, 8'h08, rd);
    bus(1'b0, PTBI_OFS_CTRL, 8'h0, rd);
    chk("wait read", rd, 32'h0);
    xtal(4);
    chk("wait count", tick_pending_flag, 1'b1);
    wait_mode <= 1'b0;
    start(3'h7, 1'b1);
    stop_mode <= 1'b1;
    xtal(8);
    chk("stop frozen", tick_pending_flag, 1'b0);
    chk("no wake", tick_wakeup, 1'b0);
    stop_mode <= 1'b0;
    bus(1'b1, PTBI_OFS_CFG, 8'h01, rd);
    start(3'h7, 1'b1);
    stop_mode <= 1'b1;
    xtal(4);
    chk("stop run", tick_pending_flag, 1'b1);
    chk("wake", tick_wakeup, 1'b1);
    stop_mode <= 1'b0;
    bus(1'b1, PTBI_OFS_CTRL, 8'h08, rd);
    stop_mode <= 1'b1;
    xtal(8);
    chk("off in stop", tick_pending_flag, 1'b0);
    chk("off no wake", tick_wakeup, 1'b0);
    stop_mode <= 1'b0;
  endtask : t_low_power

  // reset while counting with a request up clears both enables
  task automatic t_mid_reset();
    start(3'h7, 1'b1);
    xtal(4);
    chk("irq before rst", tick_irq, 1'b1);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    chk("irq rst", tick_irq, 1'b0);
    chk("pend rst", tick_pending_flag, 1'b0);
    bus(1'b0, PTBI_OFS_CTRL, 8'h0, rd);
    chk("ctrl rst", rd, 32'h0);
  endtask : t_mid_reset

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_rates();
    t_ack_mask();
    t_low_power();
    t_mid_reset();
    test_done();
  end
endmodule : testbench
